// >>> ncl_defs.svh
// register offsets, field positions and reset values of the command launch block
// assumes a 32-bit axi4-lite slave with byte addresses and word-aligned registers
`ifndef NCL_DEFS_SVH
`define NCL_DEFS_SVH

//****************************************************************
// register byte offsets
//****************************************************************
`define NCL_OFS_DIV      8'h00
`define NCL_OFS_STAT     8'h04
`define NCL_OFS_CFG      8'h08
`define NCL_OFS_IDX      8'h0C
`define NCL_OFS_OBJ      8'h10
`define NCL_OFS_ECFG     8'h14
`define NCL_OFS_ESTAT    8'h18
`define NCL_OFS_SEC      8'h1C

//****************************************************************
// field positions
//****************************************************************
`define NCL_DIV_LD_BIT   7
`define NCL_DIV_MSB      5
`define NCL_STAT_CC_BIT  7
`define NCL_STAT_AE_BIT  5
`define NCL_STAT_PV_BIT  4
`define NCL_CFG_COMPLETE_IRQ_ENABLE_BIT 7
`define NCL_ECC_DF_BIT   1
`define NCL_ECC_SF_BIT   0
`define NCL_SEC_BIT      0

//****************************************************************
// reset values and sizes
//****************************************************************
`define NCL_DIV_RST      6'h00
`define NCL_IDX_RST      3'h0
`define NCL_OBJ_RST      16'h0000
`define NCL_OBJ_WORDS    6
`define NCL_RESP_OKAY    2'h0
`define NCL_RESP_SLVERR  2'h2

`endif

// >>> ncl_pkg.sv
// types shared by the command launch block
// assumes ncl_defs.svh is compiled alongside
package ncl_pkg;

   //****************************************************************
   // types
   //****************************************************************
   typedef logic [15:0] ncl_word_t;
   typedef logic [7:0]  ncl_code_t;
   typedef enum logic {NCL_IDLE, NCL_BUSY} ncl_state_t;

endpackage

// >>> ncl_cmd_permit.sv
// command code screening by security state
// assumes a stable code and security level for the cycle of the check
`timescale 1ns/1ns

module ncl_cmd_permit
   import ncl_pkg::*;
(
   input  wire ncl_code_t code_in,
   input  wire logic      secured_in,
   output logic           permitted_out,
   output logic           prog_erase_out
);

   //****************************************************************
   // allowed codes per security state
   //****************************************************************
   // unsecured and secured command sets
   always_comb
   begin
      permitted_out = 1'b0;
      unique case (code_in)
         8'h01, 8'h02, 8'h08, 8'h09, 8'h0C, 8'h10: permitted_out = 1'b1;
         8'h03, 8'h04, 8'h06, 8'h07, 8'h0A, 8'h0D, 8'h11, 8'h12:
            permitted_out = !secured_in;
         8'h0B: permitted_out = secured_in;
         default: permitted_out = 1'b0;
      endcase
   end

   //****************************************************************
   // program and erase class
   //****************************************************************
   // codes that need the divider loaded
   always_comb
   begin
      prog_erase_out = 1'b0;
      unique case (code_in)
         8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h11, 8'h12: prog_erase_out = 1'b1;
         default: prog_erase_out = 1'b0;
      endcase
   end

endmodule

// >>> ncl_launch_ctrl.sv
// command front end of the nvm controller: divider, command object, launch, flags
// assumes the memory controller pulses done once per started command
// Summary of operation
// RQ1: no program or erase below 0.8 MHz
// RQ2: software picks divide value with care
// RQ3: divider write sets the loaded flag
// RQ4: loaded flag reads zero until first write
// RQ5: unloaded divider blocks program/erase, sets error
// RQ6: software clears errors, checks complete first
// RQ7: object writes ignored while command active
// RQ8: index field selects the object word
// RQ9: writing one launches and clears complete
// RQ10: object locked from launch to finish
// RQ11: complete stays low, returns at finish
// RQ12: results readable only after completion
// RQ13: indices six, seven ignore writes, read zero
// RQ14: word zero code plus high address byte
// RQ15: words two to five carry data
// RQ16: unsecured code set, no unsecure command
// RQ17: secured code set is restricted
// RQ18: complete interrupt when flag and enable
// RQ19: error interrupt from enabled ecc faults
// RQ20: software divides bus clock near 1 MHz
// RQ21: reset aborts an active command
// RQ22: refused code sets access error only
`timescale 1ns/1ns
`include "ncl_defs.svh"

module ncl_launch_ctrl
   import ncl_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              core_clk_in,
   input  wire logic              sys_rst_in,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   input  wire logic [31:0]       s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   output logic [1:0]             s_axi_bresp_out,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   output logic [31:0]            s_axi_rdata_out,
   output logic [1:0]             s_axi_rresp_out,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   // memory controller side
   input  wire logic              secured_in,
   output logic                   cmd_start_out,
   output logic [7:0]             cmd_code_out,
   output logic [23:0]            cmd_addr_out,
   output logic [15:0]            cmd_data0_out,
   output logic [15:0]            cmd_data1_out,
   output logic [15:0]            cmd_data2_out,
   output logic [15:0]            cmd_data3_out,
   output logic [5:0]             clock_divide_field_out,
   input  wire logic              cmd_done_in,
   input  wire logic              res_we_in,
   input  wire logic [2:0]        res_idx_in,
   input  wire logic [15:0]       res_data_in,
   input  wire logic              prot_viol_in,
   input  wire logic              ecc_double_in,
   input  wire logic              ecc_single_in,
   // interrupt requests
   output logic                   cmd_irq_out,
   output logic                   err_irq_out
);

   //****************************************************************
   // declarations
   //****************************************************************
   logic [ADDR_W-1:0] awaddr_ff;
   logic              aw_got_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              w_got_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [1:0]        rresp_ff;
   logic [31:0]       rdata_ff;
   logic [31:0]       nxt_rdata;
   logic              nxt_rmapped;
   logic              do_wr;
   logic              wr_mapped;
   logic [7:0]        wa;
   logic [7:0]        ra;

   ncl_state_t        state_ff;
   logic [5:0]        div_ff;
   logic              div_loaded_ff;
   logic              acc_err_ff;
   logic              prot_viol_ff;
   logic              complete_irq_enable_ff;
   logic [2:0]        idx_ff;
   logic              df_ie_ff;
   logic              sf_ie_ff;
   logic              df_flag_ff;
   logic              sf_flag_ff;
   logic              start_ff;
   ncl_word_t         obj_ff [`NCL_OBJ_WORDS];

   logic              command_complete_flag;
   logic              launch_req;
   logic              launch_ok;
   logic              launch_bad;
   logic              permitted;
   logic              prog_erase;
   logic              wr_div;
   logic              wr_stat;
   logic              wr_cfg;
   logic              wr_idx;
   logic              wr_obj;
   logic              wr_ecfg;
   logic              wr_estat;

   //****************************************************************
   // axi4-lite write channels
   //****************************************************************
   assign s_axi_awready_out = !aw_got_ff && !bvalid_ff;
   assign s_axi_wready_out  = !w_got_ff && !bvalid_ff;
   assign s_axi_bvalid_out  = bvalid_ff;
   assign s_axi_bresp_out   = bresp_ff;
   assign do_wr             = aw_got_ff && w_got_ff && !bvalid_ff;
   assign wa                = awaddr_ff[7:0];

   // address and data taken in either order
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff  <= 32'h00000000;
         wstrb_ff  <= 4'h0;
      end
      else if (do_wr)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata_in;
            wstrb_ff <= s_axi_wstrb_in;
         end
      end
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `NCL_RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_mapped ? `NCL_RESP_OKAY : `NCL_RESP_SLVERR;
      end
      else if (s_axi_bready_in)
         bvalid_ff <= 1'b0;
   end

   // write address decode
   assign wr_div    = do_wr && (wa == `NCL_OFS_DIV);
   assign wr_stat   = do_wr && (wa == `NCL_OFS_STAT);
   assign wr_cfg    = do_wr && (wa == `NCL_OFS_CFG);
   assign wr_idx    = do_wr && (wa == `NCL_OFS_IDX);
   assign wr_obj    = do_wr && (wa == `NCL_OFS_OBJ);
   assign wr_ecfg   = do_wr && (wa == `NCL_OFS_ECFG);
   assign wr_estat  = do_wr && (wa == `NCL_OFS_ESTAT);
   assign wr_mapped = (wa == `NCL_OFS_DIV) || (wa == `NCL_OFS_STAT) ||
                      (wa == `NCL_OFS_CFG) || (wa == `NCL_OFS_IDX) ||
                      (wa == `NCL_OFS_OBJ) || (wa == `NCL_OFS_ECFG) ||
                      (wa == `NCL_OFS_ESTAT) || (wa == `NCL_OFS_SEC);

   //****************************************************************
   // axi4-lite read channels
   //****************************************************************
   assign s_axi_arready_out = !rvalid_ff;
   assign s_axi_rvalid_out  = rvalid_ff;
   assign s_axi_rdata_out   = rdata_ff;
   assign s_axi_rresp_out   = rresp_ff;
   assign ra                = s_axi_araddr_in[7:0];

   // read data mux
   always_comb
   begin
      nxt_rdata   = 32'h00000000;
      nxt_rmapped = 1'b1;
      unique case (ra)
         `NCL_OFS_DIV:
         begin
            nxt_rdata[`NCL_DIV_LD_BIT]   = div_loaded_ff;
            nxt_rdata[`NCL_DIV_MSB:0]    = div_ff;
         end
         `NCL_OFS_STAT:
         begin
            nxt_rdata[`NCL_STAT_CC_BIT]  = command_complete_flag;
            nxt_rdata[`NCL_STAT_AE_BIT]  = acc_err_ff;
            nxt_rdata[`NCL_STAT_PV_BIT]  = prot_viol_ff;
         end
         `NCL_OFS_CFG:   nxt_rdata[`NCL_CFG_COMPLETE_IRQ_ENABLE_BIT] = complete_irq_enable_ff;
         `NCL_OFS_IDX:   nxt_rdata[2:0] = idx_ff;
         `NCL_OFS_OBJ:
         begin
            // RQ12 results after completion
            // RQ13 unused indices read zero
            if (command_complete_flag && (idx_ff < 3'(`NCL_OBJ_WORDS)))
               nxt_rdata[15:0] = obj_ff[idx_ff];
         end
         `NCL_OFS_ECFG:
         begin
            nxt_rdata[`NCL_ECC_DF_BIT]   = df_ie_ff;
            nxt_rdata[`NCL_ECC_SF_BIT]   = sf_ie_ff;
         end
         `NCL_OFS_ESTAT:
         begin
            nxt_rdata[`NCL_ECC_DF_BIT]   = df_flag_ff;
            nxt_rdata[`NCL_ECC_SF_BIT]   = sf_flag_ff;
         end
         `NCL_OFS_SEC:   nxt_rdata[`NCL_SEC_BIT] = secured_in;
         default:        nxt_rmapped = 1'b0;
      endcase
   end

   // registered read answer one cycle after the address
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= `NCL_RESP_OKAY;
      end
      else if (s_axi_arvalid_in && s_axi_arready_out)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rmapped ? `NCL_RESP_OKAY : `NCL_RESP_SLVERR;
      end
      else if (s_axi_rready_in)
         rvalid_ff <= 1'b0;
   end

   //****************************************************************
   // clock divider
   //****************************************************************
   // RQ3 RQ4 loaded flag on write
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         div_ff        <= `NCL_DIV_RST;
         div_loaded_ff <= 1'b0;
      end
      else if (wr_div)
      begin
         div_loaded_ff <= 1'b1;
         if (wstrb_ff[0])
            div_ff <= wdata_ff[`NCL_DIV_MSB:0];
      end
   end
   assign clock_divide_field_out = div_ff;

   //****************************************************************
   // command screening and launch
   //****************************************************************
   ncl_cmd_permit u_permit
   (
      .code_in        (obj_ff[0][15:8]),
      .secured_in     (secured_in),
      .permitted_out  (permitted),
      .prog_erase_out (prog_erase)
   );

   assign command_complete_flag       = (state_ff == NCL_IDLE);
   assign launch_req = wr_stat && wstrb_ff[0] && wdata_ff[`NCL_STAT_CC_BIT] && command_complete_flag &&
                       !acc_err_ff && !prot_viol_ff;
   // RQ5 RQ16 RQ17 RQ22 refuse bad launch
   assign launch_bad = launch_req && (!permitted || (prog_erase && !div_loaded_ff));
   assign launch_ok  = launch_req && !launch_bad;

   // RQ9 RQ11 RQ21 launch and completion
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         state_ff <= NCL_IDLE;
         start_ff <= 1'b0;
      end
      else
      begin
         start_ff <= launch_ok;
         unique case (state_ff)
            NCL_IDLE: if (launch_ok) state_ff <= NCL_BUSY;
            NCL_BUSY: if (cmd_done_in) state_ff <= NCL_IDLE;
         endcase
      end
   end
   assign cmd_start_out = start_ff;

   // status error flags, set wins over clear
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         acc_err_ff   <= 1'b0;
         prot_viol_ff <= 1'b0;
      end
      else
      begin
         // RQ5 access error on refusal
         if (launch_bad)
            acc_err_ff <= 1'b1;
         else if (wr_stat && wstrb_ff[0] && wdata_ff[`NCL_STAT_AE_BIT])
            acc_err_ff <= 1'b0;
         if (prot_viol_in)
            prot_viol_ff <= 1'b1;
         else if (wr_stat && wstrb_ff[0] && wdata_ff[`NCL_STAT_PV_BIT])
            prot_viol_ff <= 1'b0;
      end
   end

   //****************************************************************
   // command object array
   //****************************************************************
   // RQ8 index select register
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         idx_ff <= `NCL_IDX_RST;
      else if (wr_idx && wstrb_ff[0])
         idx_ff <= wdata_ff[2:0];
   end

   // one word per index, software or controller results
   for (genvar g = 0; g < `NCL_OBJ_WORDS; g++)
   begin : g_obj
      always_ff @(posedge core_clk_in)
      begin
         if (sys_rst_in)
            obj_ff[g] <= `NCL_OBJ_RST;
         // RQ7 RQ10 locked while active
         else if (wr_obj && command_complete_flag && (idx_ff == 3'(g)))
         begin
            if (wstrb_ff[0])
               obj_ff[g][7:0] <= wdata_ff[7:0];
            if (wstrb_ff[1])
               obj_ff[g][15:8] <= wdata_ff[15:8];
         end
         // RQ11 results placed while the command is active
         else if (res_we_in && !command_complete_flag && (res_idx_in == 3'(g)))
            obj_ff[g] <= res_data_in;
      end
   end

   // RQ14 RQ15 parameter fields to controller
   assign cmd_code_out  = obj_ff[0][15:8];
   assign cmd_addr_out  = {obj_ff[0][7:0], obj_ff[1]};
   assign cmd_data0_out = obj_ff[2];
   assign cmd_data1_out = obj_ff[3];
   assign cmd_data2_out = obj_ff[4];
   assign cmd_data3_out = obj_ff[5];

   //****************************************************************
   // configuration and ecc fault flags
   //****************************************************************
   // interrupt enables
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         complete_irq_enable_ff  <= 1'b0;
         df_ie_ff <= 1'b0;
         sf_ie_ff <= 1'b0;
      end
      else
      begin
         if (wr_cfg && wstrb_ff[0])
            complete_irq_enable_ff <= wdata_ff[`NCL_CFG_COMPLETE_IRQ_ENABLE_BIT];
         if (wr_ecfg && wstrb_ff[0])
         begin
            df_ie_ff <= wdata_ff[`NCL_ECC_DF_BIT];
            sf_ie_ff <= wdata_ff[`NCL_ECC_SF_BIT];
         end
      end
   end

   // fault flags, set wins over write-one clear
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         df_flag_ff <= 1'b0;
         sf_flag_ff <= 1'b0;
      end
      else
      begin
         if (ecc_double_in)
            df_flag_ff <= 1'b1;
         else if (wr_estat && wstrb_ff[0] && wdata_ff[`NCL_ECC_DF_BIT])
            df_flag_ff <= 1'b0;
         if (ecc_single_in)
            sf_flag_ff <= 1'b1;
         else if (wr_estat && wstrb_ff[0] && wdata_ff[`NCL_ECC_SF_BIT])
            sf_flag_ff <= 1'b0;
      end
   end

   //****************************************************************
   // interrupt requests
   //****************************************************************
   // RQ18 completion request
   assign cmd_irq_out = command_complete_flag && complete_irq_enable_ff;
   // RQ19 ecc fault request
   assign err_irq_out = (df_flag_ff && df_ie_ff) || (sf_flag_ff && sf_ie_ff);

endmodule

// >>> ncl_launch_ctrl_chk.sv
// port-level assertions for the command launch block
// assumes it is bound into ncl_launch_ctrl with its default address width
`timescale 1ns/1ns

module ncl_launch_ctrl_chk
(
   input  wire logic        core_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        s_axi_awready_out,
   input  wire logic        s_axi_wready_out,
   input  wire logic [1:0]  s_axi_bresp_out,
   input  wire logic        s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic        s_axi_arvalid_in,
   input  wire logic        s_axi_arready_out,
   input  wire logic [31:0] s_axi_rdata_out,
   input  wire logic        s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   input  wire logic        cmd_start_out,
   input  wire logic        cmd_done_in,
   input  wire logic        cmd_irq_out,
   input  wire logic        err_irq_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   logic busy_ff;

   //********************
   // command tracker
   //********************
   // set by the launch pulse, cleared by done
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         busy_ff <= 1'b0;
      else if (cmd_start_out)
         busy_ff <= 1'b1;
      else if (cmd_done_in)
         busy_ff <= 1'b0;
   end

   //********************
   // assertions
   //********************
   a_start_pulse: assert property (cmd_start_out |=> !cmd_start_out)
      else $error("launch pulse longer than one cycle");
   a_start_with_b: assert property (cmd_start_out |-> $rose(s_axi_bvalid_out))
      else $error("launch pulse not with write response");
   a_irq_busy: assert property (cmd_start_out || busy_ff |-> !cmd_irq_out)
      else $error("complete interrupt while busy");
   a_no_relaunch: assert property (busy_ff |-> !cmd_start_out)
      else $error("second launch while busy");
   a_b_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped early");
   a_r_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped early");
   a_b_blocks: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write accepted during response");
   a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
      |=> s_axi_rvalid_out && !s_axi_arready_out)
      else $error("read not answered next cycle");

   c_launch: cover property (cmd_start_out);
   c_done: cover property (busy_ff && cmd_done_in);
   c_err: cover property (err_irq_out);
endmodule

// >>> tb.sv
// self-checking bench for the command launch block
// assumes ncl_defs.svh and ncl_pkg are compiled first
`timescale 1ns/1ns
`include "ncl_defs.svh"
`define CHK(e, g) \
   begin \
      logic [95:0] x_; \
      x_ = 96'(e); \
      tests_run++; \
      if (96'(g) !== x_) \
      begin \
         mismatches++; \
         $display("BAD t=%0t exp=%0h got=%0h", $time, x_, 96'(g)); \
      end \
   end

module tb
   import ncl_pkg::*;
;
   logic        clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, secured = 0, done = 0, res_we = 0, pviol = 0;
   logic        awready, wready, bvalid, arready, rvalid, cmd_start, cmd_irq, err_irq;
   logic [1:0]  ecc = 0, bresp, rresp;
   logic [7:0]  awaddr = 0, araddr = 0, cmd_code;
   logic [31:0] wdata = 0, rdata;
   logic [2:0]  res_idx = 0;
   logic [15:0] res_data = 0, cd0, cd1, cd2, cd3;
   logic [23:0] cmd_addr;
   logic [5:0]  divf, div;
   logic [15:0] obj_w [6];
   ncl_code_t   codes [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                               8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12};
   int          mismatches = 0, tests_run = 0, seed = 32'hAF7085A4;
   logic [33:0] rq [$];
   logic [1:0]  bq [$];
   logic [95:0] cq [$];

   // bus clock far above the program limit
   always #10 clk = ~clk;

   ncl_launch_ctrl u_ncl_launch_ctrl
   (
      .core_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .secured_in(secured), .cmd_start_out(cmd_start),
      .cmd_code_out(cmd_code), .cmd_addr_out(cmd_addr), .cmd_data0_out(cd0),
      .cmd_data1_out(cd1), .cmd_data2_out(cd2), .cmd_data3_out(cd3),
      .clock_divide_field_out(divf), .cmd_done_in(done), .res_we_in(res_we),
      .res_idx_in(res_idx), .res_data_in(res_data), .prot_viol_in(pviol),
      .ecc_double_in(ecc[1]), .ecc_single_in(ecc[0]), .cmd_irq_out(cmd_irq),
      .err_irq_out(err_irq)
   );

   //********************
   // bus tasks
   //********************
   // write with both halves offered together, bready held up until bvalid is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (!bvalid) bready <= 1'b1;
      end
      while (!bvalid);
      bready <= 1'b0;
   endtask

   // read, expected word noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      rq.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (!rvalid) rready <= 1'b1;
      end
      while (!rvalid);
      rready <= 1'b0;
   endtask

   // fill all eight indices, read each back
   task automatic load_obj(input ncl_code_t c);
      obj_w[0] = {c, 8'($random(seed))};
      for (int i = 1; i < 6; i++) obj_w[i] = 16'($random(seed));
      for (int i = 0; i < 8; i++)
      begin
         wr(`NCL_OFS_IDX, i);
         wr(`NCL_OFS_OBJ, (i < 6) ? obj_w[i] : 16'($random(seed)));
         rd(`NCL_OFS_OBJ, (i < 6) ? obj_w[i] : 16'h0000);
      end
   endtask

   function automatic bit ok(input ncl_code_t c, input bit s);
      if (s) return c inside {8'h01, 8'h02, 8'h08, 8'h09, 8'h0B, 8'h0C, 8'h10};
      return c inside {[8'h01:8'h04], [8'h06:8'h0A], 8'h0C, 8'h0D, [8'h10:8'h12]};
   endfunction

   task automatic give_verdict;
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   //********************
   // monitor and watchdog
   //********************
   // oldest note is compared whenever a result appears
   always @(posedge clk)
   begin
      if (bvalid && bready) `CHK(bq.pop_front(), bresp)
      if (rvalid && rready) `CHK(rq.pop_front(), {rresp, rdata})
      if (cmd_start) `CHK(cq.pop_front(), {cmd_code, cmd_addr, cd0, cd1, cd2, cd3})
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      mismatches++;
      give_verdict();
   end

   //********************
   // scenarios
   //********************
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(`NCL_OFS_DIV, 32'h0);
      rd(`NCL_OFS_STAT, 32'h80);
      rd(8'h20, 32'h0, `NCL_RESP_SLVERR);
      wr(8'h20, 32'h0, `NCL_RESP_SLVERR);
      load_obj(8'h06);
      wr(`NCL_OFS_STAT, 32'h80);
      rd(`NCL_OFS_STAT, 32'hA0);
      wr(`NCL_OFS_STAT, 32'h20);
      div = 6'($random(seed));
      // divider loaded before any program or erase
      wr(`NCL_OFS_DIV, div);
      rd(`NCL_OFS_DIV, {24'h0, 2'h2, div});
      `CHK(div, divf)
      wr(`NCL_OFS_CFG, 32'h80);
      for (int s = 0; s < 2; s++)
         for (int k = 0; k < 16; k++)
         begin
            secured <= s[0];
            load_obj(codes[k]);
            if (ok(codes[k], s[0]))
               cq.push_back({obj_w[0], obj_w[1], obj_w[2], obj_w[3], obj_w[4], obj_w[5]});
            wr(`NCL_OFS_STAT, 32'h80);
            if (ok(codes[k], s[0]))
            begin
               rd(`NCL_OFS_STAT, 32'h0);
               `CHK(1'b0, cmd_irq)
               wr(`NCL_OFS_IDX, 32'h0);
               wr(`NCL_OFS_OBJ, ~obj_w[0]);
               rd(`NCL_OFS_OBJ, 32'h0);
               res_we <= 1'b1;
               res_idx <= 3'h2;
               res_data <= 16'($random(seed));
               @(posedge clk);
               res_we <= 1'b0;
               done <= 1'b1;
               @(posedge clk);
               done <= 1'b0;
               rd(`NCL_OFS_STAT, 32'h80);
               `CHK(1'b1, cmd_irq)
               for (int i = 0; i < 6; i++)
               begin
                  wr(`NCL_OFS_IDX, i);
                  rd(`NCL_OFS_OBJ, (i == 2) ? res_data : obj_w[i]);
               end
            end
            else
            begin
               rd(`NCL_OFS_STAT, 32'hA0);
               wr(`NCL_OFS_STAT, 32'h20);
            end
         end
      rd(`NCL_OFS_SEC, 32'h1);
      for (int b = 0; b < 2; b++)
      begin
         wr(`NCL_OFS_ECFG, 32'h2 >> b);
         ecc <= 2'h1 << b;
         @(posedge clk);
         ecc <= 2'h0;
         @(posedge clk);
         `CHK(1'b0, err_irq)
         wr(`NCL_OFS_ECFG, 32'h3);
         `CHK(1'b1, err_irq)
         wr(`NCL_OFS_ESTAT, 32'h3);
         `CHK(1'b0, err_irq)
      end
      pviol <= 1'b1;
      @(posedge clk);
      pviol <= 1'b0;
      wr(`NCL_OFS_STAT, 32'h80);
      rd(`NCL_OFS_STAT, 32'h90);
      wr(`NCL_OFS_STAT, 32'h10);
      load_obj(8'h01);
      cq.push_back({obj_w[0], obj_w[1], obj_w[2], obj_w[3], obj_w[4], obj_w[5]});
      wr(`NCL_OFS_STAT, 32'h80);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(`NCL_OFS_STAT, 32'h80);
      rd(`NCL_OFS_DIV, 32'h0);
      give_verdict();
   end
endmodule

bind ncl_launch_ctrl ncl_launch_ctrl_chk u_ncl_launch_ctrl_chk
(
   .core_clk_in, .sys_rst_in, .s_axi_awready_out, .s_axi_wready_out, .s_axi_bresp_out,
   .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
   .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .cmd_start_out, .cmd_done_in,
   .cmd_irq_out, .err_irq_out
);
